// File: logic/csb_serial.sv
// clocked serial byte interface: registers, state machine and shifter
`timescale 1ns/1ps
module csb_serial (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_inst_tick,
    input wire logic i_start,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [csb_pkg::ADDR_W-1:0] i_addr,
    input wire logic [3:0] i_wdata,
    input wire logic i_sck,
    input wire logic i_si,
    output logic [3:0] o_rdata,
    output logic o_serial_irq,
    output logic [3:0] o_pin_select,
    output logic o_sck,
    output logic o_sck_oe,
    output logic o_so,
    output logic o_so_oe
);

    // ****************************************
    // declarations
    // ****************************************
    csb_pkg::csb_state_type state;
    csb_pkg::csb_state_type next_state;
    logic [3:0] mode;
    logic [3:0] mode_pend;
    logic [1:0] apply_wait;
    logic [3:0] pin_sel;
    logic [7:0] shreg;
    logic [2:0] bit_cnt;
    logic [2:0] next_bit_cnt;
    logic req_flag;
    logic mask;
    logic armed;
    logic next_armed;
    logic sck_s1, sck_s2, sck_s3;
    logic si_s1, si_s2;
    logic gen_sck, gen_fall, gen_rise;

    // ****************************************
    // decode
    // ****************************************
    wire logic wr_ctrl = i_wr && (i_addr == csb_pkg::ADDR_INT_CTRL);
    wire logic wr_pin = i_wr && (i_addr == csb_pkg::ADDR_PIN_SEL);
    wire logic wr_mode = i_wr && (i_addr == csb_pkg::ADDR_MODE);
    wire logic wr_lo = i_wr && (i_addr == csb_pkg::ADDR_DATA_LO);
    wire logic wr_hi = i_wr && (i_addr == csb_pkg::ADDR_DATA_HI);
    // a change of the serial pin pair forces start wait like a mode write, but sets no abort request
    wire logic pin_change = wr_pin &&
        (i_wdata[csb_pkg::IN_PIN_BIT:csb_pkg::OUT_PIN_BIT] !=
         pin_sel[csb_pkg::IN_PIN_BIT:csb_pkg::OUT_PIN_BIT]);
    wire logic force_idle = wr_mode || pin_change;
    wire logic clk_pin = mode[csb_pkg::CLK_PIN_BIT];
    wire logic ext_clk = (mode[2:0] == csb_pkg::SRC_EXTERNAL);
    wire logic in_sel = pin_sel[csb_pkg::IN_PIN_BIT];
    wire logic out_sel = pin_sel[csb_pkg::OUT_PIN_BIT];
    wire logic cont_mode = clk_pin && !in_sel && !out_sel;
    wire logic int_clk = clk_pin && !ext_clk;

    // ****************************************
    // clock and data pin synchronisers
    // ****************************************
    // two-flop synchroniser
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            sck_s1 <= 1'b1;
            sck_s2 <= 1'b1;
            sck_s3 <= 1'b1;
            si_s1 <= 1'b0;
            si_s2 <= 1'b0;
        end else begin
            sck_s1 <= i_sck;
            sck_s2 <= sck_s1;
            sck_s3 <= sck_s2;
            si_s1 <= i_si;
            si_s2 <= si_s1;
        end
    end

    // edges only when the pin carries the shift clock
    wire logic ext_fall = sck_s3 && !sck_s2;
    wire logic ext_rise = !sck_s3 && sck_s2;
    wire logic fall_evt = clk_pin && (ext_clk ? ext_fall : gen_fall);
    wire logic rise_evt = clk_pin && (ext_clk ? ext_rise : gen_rise);
    // receive disabled reads zeros into the register
    wire logic si_bit = in_sel && si_s2;

    // ****************************************
    // state machine
    // ****************************************
    wire logic last_rise = (state == csb_pkg::CSB_TRANSFER) && rise_evt &&
        (bit_cnt == csb_pkg::LAST_BIT);
    wire logic abort = wr_mode && (state == csb_pkg::CSB_TRANSFER);
    wire logic restart = i_start && (state == csb_pkg::CSB_TRANSFER);

    always_comb begin
        next_state = state;
        next_bit_cnt = bit_cnt;
        next_armed = armed;
        if (force_idle) begin
            next_state = csb_pkg::CSB_START_WAIT;
            next_bit_cnt = 3'h0;
            next_armed = 1'b0;
        end else if (i_start) begin
            next_state = csb_pkg::CSB_CLOCK_WAIT;
            next_bit_cnt = 3'h0;
            next_armed = 1'b1;
        end else begin
            unique case (state)
                csb_pkg::CSB_START_WAIT: begin
                    next_state = csb_pkg::CSB_START_WAIT;
                end
                csb_pkg::CSB_CLOCK_WAIT: begin
                    if (fall_evt && !cont_mode) begin
                        next_state = csb_pkg::CSB_TRANSFER;
                    end
                end
                csb_pkg::CSB_TRANSFER: begin
                    if (rise_evt) begin
                        next_bit_cnt = bit_cnt + 3'h1;
                    end
                    if (last_rise) begin
                        next_state = csb_pkg::CSB_CLOCK_WAIT;
                        next_armed = 1'b0;
                    end
                end
            endcase
        end
    end

    // clock runs from start until eighth rising edge, in continuous mode until forced idle
    wire logic gen_run = int_clk && (next_state != csb_pkg::CSB_START_WAIT) &&
        (next_armed || cont_mode);

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            state <= csb_pkg::CSB_START_WAIT;
            bit_cnt <= 3'h0;
            armed <= 1'b0;
        end else begin
            state <= next_state;
            bit_cnt <= next_bit_cnt;
            armed <= next_armed;
        end
    end

    // ****************************************
    // mode and pin select registers
    // ****************************************
    // reset clears mode
    // value applies two instruction cycles after write
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            mode <= csb_pkg::MODE_RST;
            mode_pend <= csb_pkg::MODE_RST;
            apply_wait <= 2'h0;
        end else if (wr_mode) begin
            mode_pend <= i_wdata;
            apply_wait <= csb_pkg::MODE_APPLY_CYCLES;
        end else if (i_inst_tick && apply_wait != 2'h0) begin
            apply_wait <= apply_wait - 2'h1;
            if (apply_wait == 2'h1) begin
                mode <= mode_pend;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            pin_sel <= csb_pkg::PIN_SEL_RST;
        end else if (wr_pin) begin
            pin_sel <= i_wdata;
        end
    end

    // ****************************************
    // shift data register
    // ****************************************
    // software write wins over a shift; reads during shifting are not safe
    wire logic shifting = (state == csb_pkg::CSB_TRANSFER) && !force_idle && !i_start;

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            shreg <= 8'h00;
        end else if (wr_lo) begin
            shreg[3:0] <= i_wdata;
        end else if (wr_hi) begin
            shreg[7:4] <= i_wdata;
        end else if (shifting && rise_evt) begin
            shreg <= {si_bit, shreg[7:1]};
        end
    end

    // ****************************************
    // request flag and mask
    // ****************************************
    // completion, abort or a restart during transfer sets the request
    wire logic req_set = (last_rise && !force_idle && !i_start) || abort || restart;
    wire logic req_clr = wr_ctrl && !i_wdata[csb_pkg::REQ_BIT];

    // set wins over a clear in the same cycle
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            req_flag <= csb_pkg::REQ_RST;
            mask <= csb_pkg::MASK_RST;
        end else begin
            req_flag <= req_set || (req_flag && !req_clr);
            if (wr_ctrl) begin
                mask <= i_wdata[csb_pkg::MASK_BIT];
            end
        end
    end

    // ****************************************
    // read port and pins
    // ****************************************
    wire logic [3:0] ctrl_rd = {2'h0, mask, req_flag};
    wire logic [3:0] rd_mux =
        (i_addr == csb_pkg::ADDR_INT_CTRL) ? ctrl_rd :
        (i_addr == csb_pkg::ADDR_DATA_LO) ? shreg[3:0] :
        (i_addr == csb_pkg::ADDR_DATA_HI) ? shreg[7:4] : 4'h0;

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_rdata <= 4'h0;
            o_serial_irq <= 1'b0;
            o_pin_select <= csb_pkg::PIN_SEL_RST;
            o_sck <= 1'b1;
            o_sck_oe <= 1'b0;
            o_so <= 1'b1;
            o_so_oe <= 1'b0;
        end else begin
            if (i_rd) begin
                o_rdata <= rd_mux;
            end
            o_serial_irq <= req_flag && !mask;
            o_pin_select <= pin_sel;
            o_sck <= gen_sck;
            // external clock leaves the pin undriven
            o_sck_oe <= int_clk;
            o_so_oe <= out_sel;
            if (fall_evt && (state == csb_pkg::CSB_TRANSFER ||
                             state == csb_pkg::CSB_CLOCK_WAIT) && !force_idle) begin
                o_so <= shreg[0];
            end
        end
    end

    // ****************************************
    // shift clock generator
    // ****************************************
    // divider ratio from clock select
    wire logic [csb_pkg::HALF_W-1:0] half_sel =
        ext_clk ? csb_pkg::SCK_HALF[0] : csb_pkg::SCK_HALF[mode[2:0]];

    csb_sck_gen #(
        .HALF_W(csb_pkg::HALF_W)
    ) u_sck_gen (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_run(gen_run),
        .i_half(half_sel),
        .o_sck(gen_sck),
        .o_fall(gen_fall),
        .o_rise(gen_rise)
    );

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    AST_START_CLEARS: assert property (
        i_start && !force_idle |=> bit_cnt == 3'h0 && state == csb_pkg::CSB_CLOCK_WAIT)
        else $error("start did not clear counter");

    AST_MODE_WR_IDLE: assert property (
        wr_mode |=> state == csb_pkg::CSB_START_WAIT && bit_cnt == 3'h0)
        else $error("mode write did not force start wait");

    AST_ABORT_FLAG: assert property (
        wr_mode && state == csb_pkg::CSB_TRANSFER |=> req_flag)
        else $error("abort did not set request");

    AST_DONE_RETURN: assert property (
        last_rise && !force_idle && !i_start
        |=> state == csb_pkg::CSB_CLOCK_WAIT && req_flag && bit_cnt == 3'h0)
        else $error("eighth clock did not complete");

    AST_MASK_GATE: assert property (
        ##1 o_serial_irq == ($past(req_flag) && !$past(mask)))
        else $error("request not gated by mask");

    AST_MODE_APPLY: assert property (
        apply_wait == 2'h1 && i_inst_tick && !wr_mode |=> mode == $past(mode_pend))
        else $error("mode value not applied");

    AST_MODE_HOLD: assert property (
        wr_mode |=> mode == $past(mode) ##0 apply_wait == csb_pkg::MODE_APPLY_CYCLES)
        else $error("mode applied too early");

    AST_EXT_NO_DRIVE: assert property (
        clk_pin && ext_clk ##1 $stable(mode) |-> !o_sck_oe)
        else $error("clock pin driven in external mode");

    AST_IDLE_IGNORES: assert property (
        state == csb_pkg::CSB_START_WAIT && !i_start |=> state != csb_pkg::CSB_TRANSFER
        && bit_cnt == 3'h0)
        else $error("start wait took a clock");

    AST_SHIFT_IN: assert property (
        shifting && rise_evt && !i_wr |=> shreg[7] == $past(si_bit)
        && shreg[6:0] == $past(shreg[7:1]))
        else $error("input bit not captured");

endmodule

// File: logic/csb_pkg.sv
// shared constants and types of the clocked serial byte interface
package csb_pkg;

    // ****************************************
    // register map (digit addresses)
    // ****************************************
    localparam int ADDR_W = 10;
    localparam logic [ADDR_W-1:0] ADDR_INT_CTRL = 10'h003;
    localparam logic [ADDR_W-1:0] ADDR_PIN_SEL = 10'h004;
    localparam logic [ADDR_W-1:0] ADDR_MODE = 10'h005;
    localparam logic [ADDR_W-1:0] ADDR_DATA_LO = 10'h006;
    localparam logic [ADDR_W-1:0] ADDR_DATA_HI = 10'h007;

    // ****************************************
    // field positions
    // ****************************************
    localparam int REQ_BIT = 0;
    localparam int MASK_BIT = 1;
    localparam int CLK_PIN_BIT = 3;
    localparam int IN_PIN_BIT = 1;
    localparam int OUT_PIN_BIT = 0;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [3:0] MODE_RST = 4'h0;
    localparam logic [3:0] PIN_SEL_RST = 4'h0;
    localparam logic MASK_RST = 1'b1;
    localparam logic REQ_RST = 1'b0;

    // ****************************************
    // timing and encodings
    // ****************************************
    localparam logic [1:0] MODE_APPLY_CYCLES = 2'h2;
    localparam logic [2:0] SRC_EXTERNAL = 3'h7;
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam int HALF_W = 12;
    // half shift clock periods in system clocks, index is the clock select
    localparam logic [HALF_W-1:0] SCK_HALF [0:6] = '{12'h800, 12'h200, 12'h080,
        12'h020, 12'h008, 12'h002, 12'h001};

    typedef enum logic [1:0] {
        CSB_START_WAIT,
        CSB_CLOCK_WAIT,
        CSB_TRANSFER
    } csb_state_type;

endpackage

// File: logic/csb_sck_gen.sv
// shift clock generator: divided system clock with edge pulses
`timescale 1ns/1ps
module csb_sck_gen #(
    parameter int HALF_W = 12
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_run,
    input wire logic [HALF_W-1:0] i_half,
    output logic o_sck,
    output logic o_fall,
    output logic o_rise
);

    logic [HALF_W-1:0] cnt;
    wire logic toggle = i_run && (cnt == i_half - {{(HALF_W-1){1'b0}}, 1'b1});

    // ****************************************
    // divider
    // ****************************************
    // idles high so the first edge of a burst is always a falling one
    always_ff @(posedge i_clk) begin
        if (!i_rst_n || !i_run) begin
            cnt <= '0;
            o_sck <= 1'b1;
            o_fall <= 1'b0;
            o_rise <= 1'b0;
        end else begin
            cnt <= toggle ? '0 : cnt + {{(HALF_W-1){1'b0}}, 1'b1};
            o_fall <= toggle && o_sck;
            o_rise <= toggle && !o_sck;
            if (toggle) begin
                o_sck <= !o_sck;
            end
        end
    end

endmodule

// File: verification/csb_far_end.sv
// far-end serial partner model of the clocked serial byte interface
`timescale 1ns/1ps
module csb_far_end (
    input wire logic i_sck,
    input wire logic i_so,
    input wire logic i_load,
    input wire logic i_ext_run,
    input wire logic [7:0] i_tx,
    output logic o_sck,
    output logic o_si,
    output logic [7:0] o_rx
);
    logic [7:0] tx_q = 8'h00;
    logic [3:0] bit_n = 4'h8;

    // ****************************************
    // link behaviour
    // ****************************************
    initial begin
        o_sck = 1'b1;
        o_si = 1'b1;
        o_rx = 8'h00;
    end

    // own clock, eight pulses
    // idle high between frames, like the pull-up
    always @(posedge i_ext_run) begin
        #3;
        repeat (8) begin
            o_sck = 1'b0;
            #80;
            o_sck = 1'b1;
            #80;
        end
    end

    always @(posedge i_load) begin
        tx_q = i_tx;
        bit_n = 4'h0;
        o_si = i_tx[0];
    end

    always @(negedge i_sck) begin
        if (bit_n != 4'h0 && bit_n < 4'h8) o_si = tx_q[bit_n[2:0]];
    end

    // device bit taken on rises
    // line inverted 60 ns after the last bit, so stale data cannot pass
    always @(posedge i_sck) begin
        if (bit_n < 4'h8) begin
            o_rx = {i_so, o_rx[7:1]};
            bit_n = bit_n + 4'h1;
            if (bit_n == 4'h8) o_si <= #60 ~o_si;
        end
    end
endmodule

// File: verification/csb_serial_test.sv
// self-checking bench of the clocked serial byte interface
`timescale 1ns/1ps
module csb_serial_test;
    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic i_inst_tick = 1'b0;
    logic i_start = 1'b0;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [csb_pkg::ADDR_W-1:0] i_addr = 10'h000;
    logic [3:0] i_wdata = 4'h0;
    logic [3:0] o_rdata, o_pin_select;
    logic o_serial_irq, o_sck, o_sck_oe, o_so, o_so_oe, far_sck, far_si;
    logic ld = 1'b0;
    logic run = 1'b0;
    logic [7:0] far_tx = 8'h00;
    logic [7:0] far_rx;
    logic [1:0] ph = 2'h0;
    logic sck_q = 1'b1;
    int miscompares = 0;
    int checked = 0;
    int cyc = 0;
    int falls = 0;
    int gap = 0;
    int last = 0;
    logic old_oe = 1'b0;
    // undriven shared pins float high through pull-ups
    wire sck_w = o_sck_oe ? o_sck : far_sck;
    wire so_w = o_so_oe ? o_so : 1'b1;

    csb_serial dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_inst_tick(i_inst_tick),
        .i_start(i_start), .i_wr(i_wr), .i_rd(i_rd), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_sck(sck_w), .i_si(far_si), .o_rdata(o_rdata), .o_serial_irq(o_serial_irq),
        .o_pin_select(o_pin_select), .o_sck(o_sck), .o_sck_oe(o_sck_oe), .o_so(o_so),
        .o_so_oe(o_so_oe));
    csb_far_end far (.i_sck(sck_w), .i_so(so_w), .i_load(ld), .i_ext_run(run),
        .i_tx(far_tx), .o_sck(far_sck), .o_si(far_si), .o_rx(far_rx));

    // ****************************************
    // clock, instruction ticks, monitor
    // ****************************************
    always #5 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        ph <= ph + 2'h1;
        i_inst_tick <= (ph == 2'h3);
        sck_q <= sck_w;
        cyc <= cyc + 1;
        if (sck_q && !sck_w) begin
            falls <= falls + 1;
            gap <= cyc - last;
            last <= cyc;
        end
        // about 50k cycles expected, slowest divider dominates
        if (cyc == 90000) begin
            miscompares++;
            wrap_up();
        end
    end

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string w);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: %s got %0h want %0h", $time, w, got, exp);
        end
    endtask
    task automatic wr(input logic [csb_pkg::ADDR_W-1:0] a, input logic [3:0] d);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
        // idle edge, so a following write never retouches the strobe in one step
        @(posedge i_clk);
    endtask
    task automatic rdc(input logic [csb_pkg::ADDR_W-1:0] a, input logic [3:0] e, string w);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        @(posedge i_clk);
        chk(o_rdata, e, w);
    endtask
    task automatic put(input logic [7:0] b);
        wr(csb_pkg::ADDR_DATA_LO, b[3:0]);
        wr(csb_pkg::ADDR_DATA_HI, b[7:4]);
    endtask
    task automatic data_is(input logic [7:0] e, input string w);
        rdc(csb_pkg::ADDR_DATA_LO, e[3:0], w);
        rdc(csb_pkg::ADDR_DATA_HI, e[7:4], w);
    endtask
    task automatic mode(input logic [3:0] m);
        int n = 0;
        // own write, so ticks are counted from the edge that takes it
        i_wr <= 1'b1;
        i_addr <= csb_pkg::ADDR_MODE;
        i_wdata <= m;
        @(posedge i_clk);
        i_wr <= 1'b0;
        while (n < 2) begin
            @(posedge i_clk);
            if (i_inst_tick) n++;
            // old mode still drives the pin until the second tick
            if (n == 1) chk(o_sck_oe, old_oe, "mode early");
        end
        old_oe = m[3] && (m[2:0] != csb_pkg::SRC_EXTERNAL);
        repeat (3) @(posedge i_clk);
    endtask
    task automatic go(input logic [7:0] tx);
        far_tx <= tx;
        ld <= 1'b1;
        falls = 0;
        i_start <= 1'b1;
        @(posedge i_clk);
        i_start <= 1'b0;
        ld <= 1'b0;
    endtask
    task automatic ext8;
        run <= 1'b1;
        @(posedge i_clk);
        run <= 1'b0;
        repeat (160) @(posedge i_clk);
    endtask
    task automatic to_falls(input int k);
        int n = 0;
        while (falls < k && n < 300) begin
            @(posedge i_clk);
            n++;
        end
    endtask
    task automatic wait_irq(input int lim);
        int n = 0;
        while (o_serial_irq !== 1'b1 && n < lim) begin
            @(posedge i_clk);
            n++;
        end
        chk(o_serial_irq, 1'b1, "irq");
        rdc(csb_pkg::ADDR_INT_CTRL, 4'h1, "flag");
        wr(csb_pkg::ADDR_INT_CTRL, 4'h0);
        @(posedge i_clk);
        // stale request must drop before the next wait starts
        chk(o_serial_irq, 1'b0, "irq clear");
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset;
        chk(o_pin_select, 4'h0, "pin select");
        chk({o_sck_oe, o_so_oe, o_serial_irq}, 3'h0, "enables");
        rdc(csb_pkg::ADDR_INT_CTRL, 4'h2, "ctrl");
        rdc(csb_pkg::ADDR_MODE, 4'h0, "mode");
        rdc(csb_pkg::ADDR_PIN_SEL, 4'h0, "pins");
        put(8'hC3);
        data_is(8'hC3, "data");
        rdc(10'h010, 4'h0, "unmapped");
    endtask
    task automatic t_int(input logic [2:0] s);
        int per;
        logic [7:0] b;
        per = (s == 3'h6) ? 2 : (4096 >> (2 * s));
        b = 8'hA5 ^ {5'h00, s};
        put(b);
        mode({1'b1, s});
        go(8'h3C + s);
        wait_irq(8 * per + 40);
        repeat (per) @(posedge i_clk);
        chk(falls, 8, "pulses");
        chk(gap, per, "period");
        chk(far_rx, b, "sent");
        // fastest rates outrun the input synchroniser
        if (s < 3'h5) data_is(8'h3C + s, "received");
    endtask
    task automatic t_ext;
        put(8'h96);
        mode(4'hF);
        go(8'h4B);
        chk({o_sck_oe, o_so_oe}, 2'h1, "pin roles");
        wr(csb_pkg::ADDR_INT_CTRL, 4'h2);
        ext8();
        chk(o_serial_irq, 1'b0, "masked");
        wr(csb_pkg::ADDR_INT_CTRL, 4'h1);
        wait_irq(4);
        chk(far_rx, 8'h96, "sent");
        data_is(8'h4B, "received");
    endtask
    task automatic t_idle;
        put(8'h5A);
        mode(4'hF);
        ext8();
        rdc(csb_pkg::ADDR_INT_CTRL, 4'h0, "idle flag");
        go(8'h00);
        wr(csb_pkg::ADDR_PIN_SEL, 4'h1);
        ext8();
        chk(o_pin_select, 4'h1, "pin copy");
        rdc(csb_pkg::ADDR_INT_CTRL, 4'h0, "pin flag");
        data_is(8'h5A, "held");
        wr(csb_pkg::ADDR_PIN_SEL, 4'h3);
    endtask
    task automatic t_abort;
        mode(4'hC);
        go(8'h00);
        to_falls(3);
        wr(csb_pkg::ADDR_MODE, 4'hC);
        wait_irq(6);
        mode(4'hC);
        go(8'h00);
        to_falls(3);
        go(8'h00);
        wait_irq(6);
        wait_irq(200);
    endtask
    task automatic t_cont;
        wr(csb_pkg::ADDR_PIN_SEL, 4'h0);
        mode(4'hD);
        go(8'h00);
        repeat (100) @(posedge i_clk);
        chk(falls > 8, 1'b1, "free run");
        chk(o_so_oe, 1'b0, "port pin");
        rdc(csb_pkg::ADDR_INT_CTRL, 4'h0, "no flag");
        mode(4'h0);
        chk(o_sck_oe, 1'b0, "clock pin");
    endtask

    task automatic wrap_up;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (3) @(posedge i_clk);
        i_rst_n <= 1'b1;
        @(posedge i_clk);
        t_reset();
        wr(csb_pkg::ADDR_INT_CTRL, 4'h0);
        wr(csb_pkg::ADDR_PIN_SEL, 4'h3);
        for (int s = 0; s < 7; s++) t_int(s[2:0]);
        t_ext();
        t_idle();
        t_abort();
        t_cont();
        wrap_up();
    end
endmodule
